// ### hw/pws_pkg.sv
// Package of constants shared by the wake/sleep sequencer and its serial port.
package pws_pkg;
    // Serial word layout: 4-bit address then two data nibbles.
    localparam int WORD_BITS = 12;
    localparam int ADDR_MSB = 11;
    localparam int ADDR_LSB = 8;
    localparam int DATA_MSB = 7;
    localparam int DATA_LSB = 0;
    // Register addresses on the serial port.
    localparam logic [3:0] ADDR_CONV1 = 4'h3;
    localparam logic [3:0] ADDR_CONV2 = 4'h4;
    localparam logic [3:0] ADDR_CLKSEL = 4'h8;
    // Field positions inside a converter voltage-code register and the clock-select register.
    localparam int CODE_MSB = 7;
    localparam int CODE_LSB = 1;
    localparam int SHUTOFF_BIT = 0;
    localparam int CLKSEL_BIT = 0;
    // Reset values loaded by the power-on reset.
    localparam logic [7:0] CONV1_RST = 8'h00;
    localparam logic [7:0] CONV2_RST = 8'h00;
    localparam logic CLKSEL_RST = 1'b0;
    // Timing counts in ref_clk cycles, then the width of their counters.
    localparam int WATCHDOG_CYCLES = 100000;
    localparam int NEGATE_CYCLES = 64;
    localparam int PG_DELAY_CYCLES = 256;
    localparam int OSC_HALF_CYCLES = 50;
    localparam int CNT_W = 20;
    // Sequencer states.
    typedef enum logic [1:0] {
        PWS_STANDBY,
        PWS_WAKING,
        PWS_RUN
    } pws_state_t;
endpackage

// ### hw/pws_ser_if.sv
// Interface carrying a received serial word from the port to the core.
`timescale 1ns/10ps
`default_nettype none
interface pws_ser_if;
    // Received 12-bit word, held until the next load.
    logic [11:0] word;
    // One-cycle pulse when a word has been loaded by the strobe.
    logic load;
    // The serial receiver drives the word.
    modport rx (output word, output load);
    // The sequencer core consumes it.
    modport core (input word, input load);
endinterface
`default_nettype wire

// ### hw/pws_serial_rx.sv
// Serial shift receiver: samples data on shift clock, loads on strobe.
`timescale 1ns/10ps
`default_nettype none
module pws_serial_rx (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic serial_shift_clock,
    input wire logic serial_data_in,
    input wire logic load_pulse,
    pws_ser_if.rx ser
);
    // Two-stage synchronisers; stage one is read only by stage two.
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    // Previous synchronised shift clock and strobe for edge finding.
    logic sck_d_reg;
    logic stb_d_reg;
    // Shift path that keeps the most recent twelve bits.
    logic [11:0] shift_reg;
    logic [11:0] word_reg;
    logic load_reg;
    wire sck_s = sync2_reg[0];
    wire data_s = sync2_reg[1];
    wire stb_s = sync2_reg[2];
    // Rising shift clock edge takes one bit in.
    wire sck_rise = sck_s & ~sck_d_reg;
    // Rising strobe edge loads the word.
    wire stb_rise = stb_s & ~stb_d_reg;

    // Synchronise the three serial pins.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= {load_pulse, serial_data_in, serial_shift_clock};
            sync2_reg <= sync1_reg;
        end
    end

    // Shift most significant bit first; older bits fall off the top.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sck_d_reg <= 1'b0;
            stb_d_reg <= 1'b0;
            shift_reg <= 12'h000;
        end else begin
            sck_d_reg <= sck_s;
            stb_d_reg <= stb_s;
            if (sck_rise) begin
                shift_reg <= {shift_reg[10:0], data_s};
            end
        end
    end

    // Capture only the last twelve bits on the strobe edge.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            word_reg <= 12'h000;
            load_reg <= 1'b0;
        end else begin
            load_reg <= stb_rise;
            if (stb_rise) begin
                word_reg <= shift_reg;
            end
        end
    end

    assign ser.word = word_reg;
    assign ser.load = load_reg;
endmodule
`default_nettype wire

// ### hw/pws_sequencer.sv
// Wake/sleep sequencer core with serial control registers.
//
// Contract
// - Strobe rise loads last twelve shifted bits.
// - Data bits sampled by serial shift clock.
// - Any wake input edge sets latch, wake.
// - Latch holds until clear; no new wake.
// - After clear, sleep drops internal wake.
// - Sleep before clear also clears latch.
// - Clear ignored while external power-good low.
// - Sleep ignored while power-good low or clear.
// - Wake still held low after sleep rewakes.
// - No clear within watchdog forces sleep.
// - Select pin picks completion power-good source.
// - Sleep switches all regulated outputs off.
// - Config bit picks internal or external clock.
// - Low-side switch grounds when power-good and clear.
// - Standby rail from battery until power-good one.
// - Internal low, external high forces sleep.
// - Power-good follows sensed output against reference.
// - Output switches on only with power-good two.
// - Converter two disable opens switch two.
// - Address three holds converter one code.
// - Address four holds converter two code.
// - Word is address then two nibbles.
// - Power-on reset initialises control registers.
`timescale 1ns/10ps
`default_nettype none
module pws_sequencer #(
    parameter int WATCHDOG_CYCLES = pws_pkg::WATCHDOG_CYCLES,
    parameter int NEGATE_CYCLES = pws_pkg::NEGATE_CYCLES,
    parameter int PG_DELAY_CYCLES = pws_pkg::PG_DELAY_CYCLES,
    parameter int OSC_HALF_CYCLES = pws_pkg::OSC_HALF_CYCLES
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic serial_shift_clock,
    input wire logic serial_data_in,
    input wire logic load_pulse,
    input wire logic [3:0] wake_key_in_n,
    input wire logic clear_in,
    input wire logic sleep_in,
    input wire logic completion_source_select,
    input wire logic converter1_above_ref,
    input wire logic converter2_above_ref,
    input wire logic ext_clock_in,
    output logic power_ok_rail1,
    output logic power_ok_rail2,
    output logic wake_active,
    output logic [3:0] wake_latched,
    output logic converter1_enable,
    output logic converter2_enable,
    output logic [6:0] converter1_code,
    output logic [6:0] converter2_code,
    output logic switched_output_1_on,
    output logic switched_output_2_on,
    output logic series_regs_enable,
    output logic standby_from_converter1,
    output logic standby_discharge,
    output logic low_side_switch_out,
    output logic low_side_switch_out_oe,
    output logic switching_clock
);
    // Serial word channel between the receiver and this core.
    pws_ser_if ser ();

    // Receiver for the three-wire serial port.
    pws_serial_rx u_rx (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .serial_shift_clock(serial_shift_clock),
        .serial_data_in(serial_data_in),
        .load_pulse(load_pulse),
        .ser(ser.rx)
    );

    // Saturating counter step used by every timer here except the oscillator divider, which wraps.
    function automatic logic [pws_pkg::CNT_W-1:0] cnt_step(
        input logic [pws_pkg::CNT_W-1:0] c,
        input int limit
    );
        if (c >= pws_pkg::CNT_W'(limit)) begin
            cnt_step = c;
        end else begin
            cnt_step = c + 1'b1;
        end
    endfunction

    // Two-flip-flop synchronisers for all pin inputs.
    logic [10:0] pin1_reg;
    logic [10:0] pin2_reg;
    wire [3:0] wake_low_s = ~pin2_reg[3:0];
    wire clear_s = pin2_reg[4];
    wire sleep_s = pin2_reg[5];
    wire seq_sel_s = pin2_reg[6];
    wire cmp1_s = pin2_reg[7];
    wire cmp2_s = pin2_reg[8];
    wire ext_clk_s = pin2_reg[9];

    // Capture pins into the ref_clk domain.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin1_reg <= 11'h00f;
            pin2_reg <= 11'h00f;
        end else begin
            pin1_reg <= {1'b0, ext_clock_in, converter2_above_ref,
                converter1_above_ref, completion_source_select,
                sleep_in, clear_in, wake_key_in_n};
            pin2_reg <= pin1_reg;
        end
    end

    // Control registers written through the serial port.
    logic [7:0] conv1_reg;
    logic [7:0] conv2_reg;
    logic clksel_reg;
    wire [3:0] ser_addr = ser.word[pws_pkg::ADDR_MSB:pws_pkg::ADDR_LSB];
    wire [7:0] ser_data = ser.word[pws_pkg::DATA_MSB:pws_pkg::DATA_LSB];
    wire wr_conv1 = ser.load && (ser_addr == pws_pkg::ADDR_CONV1);
    wire wr_conv2 = ser.load && (ser_addr == pws_pkg::ADDR_CONV2);
    wire wr_clksel = ser.load && (ser_addr == pws_pkg::ADDR_CLKSEL);

    // Reset loads defaults; loads to other addresses are ignored.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            conv1_reg <= pws_pkg::CONV1_RST;
            conv2_reg <= pws_pkg::CONV2_RST;
            clksel_reg <= pws_pkg::CLKSEL_RST;
        end else begin
            if (wr_conv1) begin
                conv1_reg <= ser_data;
            end
            if (wr_conv2) begin
                conv2_reg <= ser_data;
            end
            if (wr_clksel) begin
                clksel_reg <= ser_data[pws_pkg::CLKSEL_BIT];
            end
        end
    end

    // Power-good: internal follows comparator, external adds a delay.
    logic [pws_pkg::CNT_W-1:0] pg1_cnt_reg;
    logic [pws_pkg::CNT_W-1:0] pg2_cnt_reg;
    wire pg1_int = cmp1_s;
    wire pg2_int = cmp2_s;
    wire pg1_ext = pg1_cnt_reg >= pws_pkg::CNT_W'(PG_DELAY_CYCLES);
    wire pg2_ext = pg2_cnt_reg >= pws_pkg::CNT_W'(PG_DELAY_CYCLES);

    // Delay counters restart whenever the sensed output falls below.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pg1_cnt_reg <= '0;
            pg2_cnt_reg <= '0;
        end else begin
            pg1_cnt_reg <= pg1_int ? cnt_step(pg1_cnt_reg, PG_DELAY_CYCLES)
                : '0;
            pg2_cnt_reg <= pg2_int ? cnt_step(pg2_cnt_reg, PG_DELAY_CYCLES)
                : '0;
        end
    end

    // Completion is judged from the selected rail; then clear and
    // sleep stay negated for a further settling count.
    logic [pws_pkg::CNT_W-1:0] neg_cnt_reg;
    wire done_sel = seq_sel_s ? pg2_ext : pg1_ext;
    wire neg_open = neg_cnt_reg >= pws_pkg::CNT_W'(NEGATE_CYCLES);
    wire pg_both = pg1_ext & pg2_ext;
    wire clear_eff = clear_s & pg_both & neg_open;
    wire sleep_pin_eff = sleep_s & pg_both & ~clear_s & neg_open;

    // Negation counter runs while the completion source is good.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            neg_cnt_reg <= '0;
        end else begin
            neg_cnt_reg <= done_sel ? cnt_step(neg_cnt_reg, NEGATE_CYCLES)
                : '0;
        end
    end

    // Wake latch, internal wake and sequencer state.
    pws_pkg::pws_state_t state_reg;
    pws_pkg::pws_state_t state_next;
    logic [3:0] latch_reg;
    logic [3:0] wake_prev_reg;
    logic cleared_reg;
    logic sleep_d_reg;
    logic clear_d_reg;
    logic [pws_pkg::CNT_W-1:0] wdog_reg;
    wire [3:0] wake_rise = wake_low_s & ~wake_prev_reg;
    wire latch_empty = (latch_reg == 4'h0);
    wire wake_take = latch_empty && (wake_rise != 4'h0);
    wire sleep_rise = sleep_pin_eff & ~sleep_d_reg;
    wire clear_rise = clear_eff & ~clear_d_reg;
    wire wdog_expire = (state_reg != pws_pkg::PWS_STANDBY) && !cleared_reg
        && (wdog_reg >= pws_pkg::CNT_W'(WATCHDOG_CYCLES));
    wire pg_fault = ~pg1_int & pg1_ext;
    wire sleep_any = sleep_rise | wdog_expire
        | (pg_fault && state_reg != pws_pkg::PWS_STANDBY);
    wire wake_on = (state_reg != pws_pkg::PWS_STANDBY);

    // Next state: standby until a wake, running once clear is seen.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            pws_pkg::PWS_STANDBY: begin
                if (wake_take) begin
                    state_next = pws_pkg::PWS_WAKING;
                end
            end
            pws_pkg::PWS_WAKING: begin
                if (sleep_any) begin
                    state_next = pws_pkg::PWS_STANDBY;
                end else if (clear_rise) begin
                    state_next = pws_pkg::PWS_RUN;
                end
            end
            pws_pkg::PWS_RUN: begin
                if (sleep_any) begin
                    state_next = pws_pkg::PWS_STANDBY;
                end
            end
        endcase
    end

    // State, latch and edge history.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= pws_pkg::PWS_STANDBY;
            latch_reg <= 4'h0;
            wake_prev_reg <= 4'h0;
            cleared_reg <= 1'b0;
            sleep_d_reg <= 1'b0;
            clear_d_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sleep_d_reg <= sleep_pin_eff;
            clear_d_reg <= clear_eff;
            if (sleep_any) begin
                // Forget history so a key still held low wakes again.
                wake_prev_reg <= 4'h0;
                latch_reg <= 4'h0;
                cleared_reg <= 1'b0;
            end else begin
                wake_prev_reg <= wake_low_s;
                if (clear_eff) begin
                    latch_reg <= 4'h0;
                    cleared_reg <= wake_on;
                end else if (wake_take) begin
                    latch_reg <= wake_rise;
                end
            end
        end
    end

    // Watchdog counts from wake rising until clear is seen.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wdog_reg <= '0;
        end else if (!wake_on || cleared_reg || sleep_any) begin
            wdog_reg <= '0;
        end else begin
            wdog_reg <= cnt_step(wdog_reg, WATCHDOG_CYCLES);
        end
    end

    // Switching clock: internal oscillator divider or sampled pin.
    logic [pws_pkg::CNT_W-1:0] osc_cnt_reg;
    logic osc_reg;
    wire osc_tick = osc_cnt_reg >= pws_pkg::CNT_W'(OSC_HALF_CYCLES - 1);

    // Divider stands in for the internal oscillator.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            osc_cnt_reg <= '0;
            osc_reg <= 1'b0;
        end else if (osc_tick) begin
            osc_cnt_reg <= '0;
            osc_reg <= ~osc_reg;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 1'b1;
        end
    end

    // Derived output levels, decoded before their flip-flops.
    wire conv2_on = wake_on & ~conv2_reg[pws_pkg::SHUTOFF_BIT];
    wire conv1_on = wake_on & ~conv1_reg[pws_pkg::SHUTOFF_BIT];
    wire sw1_on = wake_on & pg2_int;
    wire sw2_on = conv2_on & pg2_int;
    wire sreg_on = wake_on & (seq_sel_s ? pg2_int : pg1_int);
    wire lsw_on = pg1_int & clear_s;
    wire clk_sel = clksel_reg ? ext_clk_s : osc_reg;

    // All outputs leave from flip-flops.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            power_ok_rail1 <= 1'b0;
            power_ok_rail2 <= 1'b0;
            wake_active <= 1'b0;
            wake_latched <= 4'h0;
            converter1_enable <= 1'b0;
            converter2_enable <= 1'b0;
            converter1_code <= 7'h00;
            converter2_code <= 7'h00;
            switched_output_1_on <= 1'b0;
            switched_output_2_on <= 1'b0;
            series_regs_enable <= 1'b0;
            standby_from_converter1 <= 1'b0;
            standby_discharge <= 1'b0;
            low_side_switch_out <= 1'b0;
            low_side_switch_out_oe <= 1'b0;
            switching_clock <= 1'b0;
        end else begin
            power_ok_rail1 <= pg1_ext;
            power_ok_rail2 <= pg2_ext;
            wake_active <= wake_on;
            wake_latched <= latch_reg;
            converter1_enable <= conv1_on;
            converter2_enable <= conv2_on;
            converter1_code <= conv1_reg[pws_pkg::CODE_MSB:pws_pkg::CODE_LSB];
            converter2_code <= conv2_reg[pws_pkg::CODE_MSB:pws_pkg::CODE_LSB];
            switched_output_1_on <= sw1_on;
            switched_output_2_on <= sw2_on;
            series_regs_enable <= sreg_on;
            standby_from_converter1 <= pg1_int;
            standby_discharge <= pg_fault;
            low_side_switch_out <= 1'b0;
            low_side_switch_out_oe <= lsw_on;
            switching_clock <= clk_sel;
        end
    end
endmodule
`default_nettype wire

// ### testbench/pws_host_model.sv
// Behavioural host that shifts words into the serial port.
`timescale 1ns/10ps
`default_nettype none
module pws_host_model (
    input wire logic ref_clk,
    input wire logic start,
    input wire logic [15:0] word,
    input wire logic [4:0] nbits,
    output var logic busy,
    output var logic serial_shift_clock,
    output var logic serial_data_in,
    output var logic load_pulse
);
    // Lines rest low, except data, which is inverted after each frame.
    initial begin
        busy = 1'b0;
        serial_shift_clock = 1'b0;
        serial_data_in = 1'b0;
        load_pulse = 1'b0;
    end
    // One frame per request, then a strobe held long enough to be seen.
    always begin
        @(posedge ref_clk iff start);
        #1;
        busy = 1'b1;
        // Bits leave MSB first, the strobe staying low meanwhile.
        for (int i = int'(nbits) - 1; i >= 0; i--) begin
            serial_data_in = word[i];
            #62.5;
            serial_shift_clock = 1'b1;
            #62.5;
            serial_shift_clock = 1'b0;
        end
        #62.5;
        load_pulse = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        load_pulse = 1'b0;
        // The stale bit must not look like a held value.
        serial_data_in = ~serial_data_in;
        busy = 1'b0;
    end
endmodule
`default_nettype wire

// ### testbench/pws_monitor.sv
// Checker of the sequencer's port timing relations.
`timescale 1ns/10ps
`default_nettype none
module pws_monitor #(
    parameter int WATCHDOG_CYCLES = 200
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] wake_key_in_n,
    input wire logic clear_in,
    input wire logic sleep_in,
    input wire logic converter1_above_ref,
    input wire logic converter2_above_ref,
    input wire logic power_ok_rail1,
    input wire logic power_ok_rail2,
    input wire logic wake_active,
    input wire logic converter1_enable,
    input wire logic converter2_enable,
    input wire logic switched_output_2_on,
    input wire logic standby_discharge,
    input wire logic low_side_switch_out,
    input wire logic low_side_switch_out_oe
);
    // Slack for pin synchronisers on top of the watchdog count.
    localparam int WD_LIMIT = WATCHDOG_CYCLES + 10;
    // Cycles of wake before any clear was seen.
    int wd_cnt;
    // Set once clear has been raised during this wake.
    logic seen_clear;
    default clocking mon_cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Counts wake time until the first clear; restarts each wake.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst || !wake_active) begin
            wd_cnt <= 0;
            seen_clear <= 1'b0;
        end else if (clear_in) begin
            seen_clear <= 1'b1;
        end else if (!seen_clear) begin
            wd_cnt <= wd_cnt + 1;
        end
    end
    chk_wake_on_key: assert property (
        $fell(&wake_key_in_n) && !wake_active && !sleep_in
        |-> ##[1:8] wake_active) else $error("key press gave no wake");
    chk_enable_needs_wake: assert property (
        converter1_enable || converter2_enable
        |-> wake_active || $past(wake_active))
        else $error("converter enabled while asleep");
    chk_sw2_needs_conv2: assert property (
        switched_output_2_on |-> converter2_enable || $past(converter2_enable))
        else $error("switch two on with converter two off");
    chk_lsw_needs_clear: assert property (
        !clear_in [*6] |=> !low_side_switch_out_oe)
        else $error("low side switch on without clear");
    chk_lsw_to_ground: assert property (
        low_side_switch_out_oe |-> !low_side_switch_out)
        else $error("low side switch drives high");
    chk_fault_sleep: assert property (
        standby_discharge |-> ##[0:8] !wake_active)
        else $error("rail one fault kept wake");
    chk_pg1_drops: assert property (
        $fell(converter1_above_ref) |-> ##[1:4] !power_ok_rail1)
        else $error("rail one good stayed high");
    chk_pg2_drops: assert property (
        $fell(converter2_above_ref) |-> ##[1:4] !power_ok_rail2)
        else $error("rail two good stayed high");
    chk_sleep_ends_wake: assert property (
        $rose(sleep_in) && !clear_in && power_ok_rail1 && power_ok_rail2
        && $past(power_ok_rail1, 8) && $past(power_ok_rail2, 8)
        |-> ##[1:12] !wake_active) else $error("sleep did not end wake");
    chk_watchdog_bound: assert property (
        wake_active && !seen_clear |-> wd_cnt <= WD_LIMIT)
        else $error("watchdog let wake run on");
    // Main scenarios reached.
    cov_wake_end: cover property ($fell(wake_active));
    cov_lsw_on: cover property (low_side_switch_out_oe);
    cov_fault: cover property (standby_discharge);
endmodule
bind pws_sequencer pws_monitor #(.WATCHDOG_CYCLES(WATCHDOG_CYCLES)) u_mon (
    .ref_clk, .nrst, .wake_key_in_n, .clear_in, .sleep_in,
    .converter1_above_ref, .converter2_above_ref, .power_ok_rail1,
    .power_ok_rail2, .wake_active, .converter1_enable, .converter2_enable,
    .switched_output_2_on, .standby_discharge, .low_side_switch_out,
    .low_side_switch_out_oe);
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the wake/sleep sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // One serial write and the codes it should leave behind.
    typedef struct {
        logic [15:0] word;
        logic [4:0] nbits;
        logic [6:0] code1;
        logic [6:0] code2;
    } pws_row_t;
    // Writes: limits, long frame, unmapped address, clock select.
    pws_row_t rows[6] = '{'{16'h03fe, 5'd12, 7'h7f, 7'h00},
        '{16'h0300, 5'd12, 7'h00, 7'h00}, '{16'h04ff, 5'd12, 7'h00, 7'h7f},
        '{16'h93aa, 5'd16, 7'h55, 7'h7f}, '{16'h05ff, 5'd12, 7'h55, 7'h7f},
        '{16'h0801, 5'd12, 7'h55, 7'h7f}};
    logic ref_clk, nrst, sck, sdi, strobe, clear_in, sleep_in, seen;
    logic comp1, comp2, ext_clock_in, host_start, host_busy;
    logic [3:0] wake_key_in_n, wake_latched;
    logic [15:0] host_word;
    logic [4:0] host_nbits;
    logic power_ok_rail1, power_ok_rail2, wake_active, converter1_enable;
    logic converter2_enable, switched_output_1_on, switched_output_2_on;
    logic standby_from_converter1, standby_discharge, switching_clock;
    logic low_side_switch_out, low_side_switch_out_oe, series_regs_enable;
    logic [6:0] converter1_code, converter2_code;
    int failures = 0;
    int total_checks = 0;
    // Short counts keep the run brief.
    pws_sequencer #(.WATCHDOG_CYCLES(200), .NEGATE_CYCLES(4),
        .PG_DELAY_CYCLES(8)) DUT (
        .ref_clk, .nrst, .serial_shift_clock(sck), .serial_data_in(sdi),
        .load_pulse(strobe), .wake_key_in_n, .clear_in, .sleep_in,
        .completion_source_select(1'b0), .converter1_above_ref(comp1),
        .converter2_above_ref(comp2), .ext_clock_in, .power_ok_rail1,
        .power_ok_rail2, .wake_active, .wake_latched, .converter1_enable,
        .converter2_enable, .converter1_code, .converter2_code,
        .switched_output_1_on, .switched_output_2_on, .series_regs_enable,
        .standby_from_converter1, .standby_discharge, .low_side_switch_out,
        .low_side_switch_out_oe, .switching_clock);
    // Host on the far side of the serial port.
    pws_host_model host (.ref_clk(ref_clk), .start(host_start),
        .word(host_word), .nbits(host_nbits), .busy(host_busy),
        .serial_shift_clock(sck), .serial_data_in(sdi), .load_pulse(strobe));
    // Counts a comparison and reports a mismatch at once.
    task automatic check(input logic [15:0] seen_v, input logic [15:0] exp);
        total_checks++;
        if (seen_v !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen_v, exp);
        end
    endtask
    // Lets n clock edges pass.
    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Waits at most n cycles for wake to reach v.
    task automatic wait_wake(input logic v, input int n);
        for (int i = 0; i < n && wake_active !== v; i++) begin
            @(posedge ref_clk);
        end
    endtask
    // Hands one frame to the host and waits until it is loaded.
    task automatic send(input logic [15:0] w, input logic [4:0] n);
        host_word <= w;
        host_nbits <= n;
        host_start <= 1'b1;
        @(posedge ref_clk);
        host_start <= 1'b0;
        cycles(2);
        for (int i = 0; i < 400 && host_busy !== 1'b0; i++) begin
            @(posedge ref_clk);
        end
        cycles(4);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Free-running 100 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Cuts a hang short well beyond the expected run length.
    initial begin
        cycles(20000);
        failures++;
        print_verdict();
    end
    // Main sequence.
    initial begin
        {nrst, host_start, clear_in, sleep_in, comp1, comp2} = 6'h00;
        {ext_clock_in, host_word, host_nbits, wake_key_in_n} = 26'h000000f;
        cycles(12);
        nrst <= 1'b1;
        cycles(2);
        check(converter1_code, 7'h00);
        check(converter2_code, 7'h00);
        check(wake_active, 1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            send(rows[i].word, rows[i].nbits);
            check(converter1_code, rows[i].code1);
            check(converter2_code, rows[i].code2);
        end
        ext_clock_in <= 1'b1;
        cycles(6);
        check(switching_clock, 1'b1);
        ext_clock_in <= 1'b0;
        cycles(6);
        check(switching_clock, 1'b0);
        $display("test writes done");
        wake_key_in_n <= 4'b1011;
        wait_wake(1'b1, 10);
        check(wake_active, 1'b1);
        check(wake_latched, 4'b0100);
        // A second key and a clear while power-good is still low.
        wake_key_in_n <= 4'b1010;
        clear_in <= 1'b1;
        cycles(8);
        check(wake_latched, 4'b0100);
        check(low_side_switch_out_oe, 1'b0);
        {clear_in, comp1, comp2} <= 3'b011;
        wake_key_in_n <= 4'hf;
        cycles(25);
        check(power_ok_rail1, 1'b1);
        check(power_ok_rail2, 1'b1);
        check(standby_from_converter1, 1'b1);
        check(switched_output_1_on, 1'b1);
        check(series_regs_enable, 1'b1);
        check(switched_output_2_on, 1'b0);
        clear_in <= 1'b1;
        cycles(6);
        check(low_side_switch_out_oe, 1'b1);
        check(wake_latched, 4'h0);
        clear_in <= 1'b0;
        cycles(6);
        check(low_side_switch_out_oe, 1'b0);
        send(16'h04a4, 5'd12);
        check(switched_output_2_on, 1'b1);
        $display("test wake and clear done");
        // Sleep while a key is held low, then release the sleep.
        wake_key_in_n <= 4'b1110;
        sleep_in <= 1'b1;
        wait_wake(1'b0, 12);
        // Rewake is at once; both stand low one cycle.
        check(wake_active, 1'b0);
        check(converter1_enable, 1'b0);
        sleep_in <= 1'b0;
        wait_wake(1'b1, 12);
        check(wake_active, 1'b1);
        wake_key_in_n <= 4'hf;
        cycles(150);
        check(wake_active, 1'b1);
        wait_wake(1'b0, 100);
        check(wake_active, 1'b0);
        $display("test sleep done");
        wake_key_in_n <= 4'b1101;
        wait_wake(1'b1, 10);
        wake_key_in_n <= 4'hf;
        cycles(20);
        comp1 <= 1'b0;
        seen = 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            seen = seen | standby_discharge;
        end
        check(seen, 1'b1);
        wait_wake(1'b0, 10);
        check(wake_active, 1'b0);
        $display("test rail fault done");
        print_verdict();
    end
endmodule
`default_nettype wire
